/* pkg/logic_cell_pkg.sv */
// Package with constants and types for the programmable logic cell
package logic_cell_pkg;

    // Operating modes, Gray coded along normal -> arithmetic -> counter
    typedef enum logic [1:0] {
        MODE_NORMAL  = 2'h0,
        MODE_ARITH   = 2'h1,
        MODE_COUNTER = 2'h3
    } mode_t;

    // Register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [3:0] LUT_MASK_ADDR = 4'h0;
    localparam logic [3:0] CELL_CTRL_ADDR = 4'h4;
    localparam logic [3:0] CELL_STATUS_ADDR = 4'h8;

    // Widths of the stored configuration
    localparam int LUT_W = 16;
    localparam int CTRL_W = 10;

    // Values after reset
    localparam logic [15:0] LUT_MASK_RST = 16'h0000;
    localparam logic [9:0] CELL_CTRL_RST = 10'h000;
    localparam logic STORE_RST = 1'h0;

    // Field positions in the control register
    localparam int MODE_LSB = 0;
    localparam int SEL0_BIT = 2;
    localparam int SEL1_BIT = 3;
    localparam int PRESET_INV_BIT = 4;
    localparam int LOAD_EMUL_BIT = 5;
    localparam int CASC_EN_BIT = 6;
    localparam int CASC_OR_BIT = 7;
    localparam int ACCUM_BIT = 8;
    localparam int CIN_LUT_BIT = 9;

    // Field positions in the status register
    localparam int ST_Q_BIT = 0;
    localparam int ST_COMB_BIT = 1;
    localparam int ST_CARRY_BIT = 2;
    localparam int ST_CASC_BIT = 3;
    localparam int ST_MODE_LSB = 4;

    // Offset of the carry half of the lookup table in three-input modes
    localparam int CARRY_HALF = 8;

endpackage : logic_cell_pkg

/* design/logic_cell.sv */
// One programmable logic cell: lookup table, register, carry and cascade
//
// Operation
// R1 - Two outputs, each selects table or register
// R2 - Registered and unregistered result at once
// R3 - Dedicated carry/cascade links, no local routing
// R4 - Carry-in feeds table and next carry stage
// R5 - Multi-cluster carry skips to same-parity cluster
// R6 - Extra cell puts final carry onto routing
// R7 - Table forms sum; register may accumulate
// R8 - Table plus carry logic makes carry-out
// R9 - Exactly one of three modes
// R10 - Seven inputs steered by mode
// R11 - Cluster register controls usable in every mode
// R12 - Counter: two 3-input tables, mux, AND
// R13 - Sync clear/load override cascade value
// R14 - Sync clear beats sync load
// R15 - Native clear; preset by inverting around register
// R16 - Preset-plus-load emulation undefined after reset
// R17 - Chip reset overrides every register control
// R18 - Inverted registers preset under chip reset
// R19 - Cascade combines table with previous cell
// R20 - Async controls act at once, beat sync
// R21 - Enable low holds register, ignores sync
`timescale 1ns/1ps
module logic_cell
    import logic_cell_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    // Data inputs from local routing
    input wire logic data_a,
    input wire logic data_b,
    input wire logic data_c,
    input wire logic data_d,
    // Chain inputs from the previous cell
    input wire logic carry_in,
    input wire logic cascade_in,
    // Cluster-wide register controls
    input wire logic reg_ena,
    input wire logic aclr,
    input wire logic apre,
    input wire logic aload,
    input wire logic adata,
    input wire logic sclr,
    input wire logic sload,
    // Chip-wide reset, active low
    input wire logic chip_reset_n,
    // Outputs toward routing and the next cell
    output logic out0,
    output logic out1,
    output logic carry_out,
    output logic cascade_out
);

    logic [LUT_W-1:0] lut_mask;   // Table contents
    logic [CTRL_W-1:0] cell_ctrl; // Mode and option bits
    logic store;                  // Physical register bit
    mode_t mode;                  // Decoded mode
    logic preset_inv;             // Register wrapped in inverters
    logic load_emul;              // Preset-plus-load emulation in use
    logic q_stored;               // Logical value of the register bit
    logic q_now;                  // Register output after async overrides
    logic async_act;              // Some asynchronous control is active
    logic async_val;              // Value forced by it
    logic comb_out;               // Table result after mode steering
    logic next_logic;             // Logical value for the next edge
    logic next_store;             // Physical value for the next edge
    logic [2:0] idx3;             // Index into a three-input half table
    logic [3:0] idx4;             // Index into the full table
    logic b_eff;                  // Operand b or register feedback
    logic d_eff;                  // Input d or carry-in
    logic sync_val;               // Value after sync load and clear

    // Decode of the control register
    // The wrapper and emulation bits change how the stored bit is read,
    // so software should only move them while the register is idle
    assign preset_inv = cell_ctrl[PRESET_INV_BIT];
    assign load_emul = cell_ctrl[LOAD_EMUL_BIT];

    // Only the three documented encodings are modes; others act as normal
    always_comb begin
        case (cell_ctrl[MODE_LSB+1:MODE_LSB])
            2'h1: mode = MODE_ARITH; // R9
            2'h3: mode = MODE_COUNTER;
            default: mode = MODE_NORMAL;
        endcase
    end

    // Configuration writes; frozen with the clock enable
    // A strobe seen while the clock enable is low is lost, not queued;
    // the master must repeat it once the cell runs again
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lut_mask <= LUT_MASK_RST;
            cell_ctrl <= CELL_CTRL_RST;
        end else if (clk_en && wr) begin
            // Unmapped addresses are ignored
            if (addr == LUT_MASK_ADDR) begin
                lut_mask <= wdata[LUT_W-1:0];
            end else if (addr == CELL_CTRL_ADDR) begin
                cell_ctrl <= wdata[CTRL_W-1:0];
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    // Read data stand until the next enabled edge and then fall back to zero,
    // so a sample after that edge sees zero rather than stale contents
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= '0;
        end else if (clk_en) begin
            rdata <= '0;
            if (rd) begin
                case (addr)
                    LUT_MASK_ADDR: begin
                        rdata[LUT_W-1:0] <= lut_mask;
                    end
                    CELL_CTRL_ADDR: begin
                        rdata[CTRL_W-1:0] <= cell_ctrl;
                    end
                    CELL_STATUS_ADDR: begin
                        rdata[ST_Q_BIT] <= q_now;
                        rdata[ST_COMB_BIT] <= comb_out;
                        rdata[ST_CARRY_BIT] <= carry_out;
                        rdata[ST_CASC_BIT] <= cascade_out;
                        rdata[ST_MODE_LSB+1:ST_MODE_LSB] <= mode;
                    end
                    default: begin
                        rdata <= '0;
                    end
                endcase
            end
        end
    end

    // Input steering; b may take the register feedback for accumulation
    assign b_eff = cell_ctrl[ACCUM_BIT] ? q_stored : data_b; // R7 R10
    // In normal mode d may take the carry-in, which lets an end cell
    // pick up the final carry and drive it onto routing
    assign d_eff = cell_ctrl[CIN_LUT_BIT] ? carry_in : data_d; // R6 R10
    assign idx4 = {d_eff, data_c, b_eff, data_a};

    // Three-input index per mode; counter uses feedback as second input
    always_comb begin
        case (mode)
            MODE_COUNTER: idx3 = {carry_in, q_stored, data_a}; // R12
            default: idx3 = {carry_in, b_eff, data_a}; // R4
        endcase
    end

    // Arithmetic and counter modes split the table into two halves of
    // eight entries; the lower half is addressed directly and the upper
    // half at the same index plus the half offset
    // Table result and carry generation per mode
    always_comb begin
        case (mode)
            MODE_ARITH: begin
                // Lower half makes the sum, upper half the carry
                comb_out = lut_mask[idx3]; // R7
                carry_out = lut_mask[CARRY_HALF + int'(idx3)]; // R8
            end
            MODE_COUNTER: begin
                // One half makes the count data, other the fast carry
                comb_out = lut_mask[idx3]; // R12
                carry_out = lut_mask[CARRY_HALF + int'(idx3)]; // R12
            end
            default: begin
                // Full four-input table; carry passes straight on
                comb_out = lut_mask[idx4];
                carry_out = carry_in; // R4
            end
        endcase
    end
    // Carry and cascade ports wire straight to the neighbour cell; the
    // fabric joins the last cell of a cluster to the first cell of the
    // next cluster of the same parity // R3 R5

    // Cascade combines this table with the previous cell's value
    // With the cascade off the table result passes on unchanged, so a
    // chain can start at any cell without a special first cell; AND
    // builds equality checks, OR builds wide any-of functions
    always_comb begin
        if (!cell_ctrl[CASC_EN_BIT]) begin
            cascade_out = comb_out;
        end else if (cell_ctrl[CASC_OR_BIT]) begin
            cascade_out = comb_out | cascade_in; // R19
        end else begin
            cascade_out = comb_out & cascade_in; // R19
        end
    end

    // Sync load mux then clear AND gate; both ahead of the cascade value
    // Clear is the last gate before the register, which is what lets it
    // win over a simultaneous load
    assign sync_val = (sload ? data_c : cascade_out) & ~sclr; // R12 R13 R14

    // Asynchronous overrides, chip reset first
    // These controls are level sensitive and modelled without a clock:
    // they show on the output at once and are written into the stored
    // bit at the next enabled edge, so a pulse narrower than one clock
    // with the clock enable low leaves no trace once it has gone
    always_comb begin
        async_act = 1'b1;
        async_val = q_stored;
        if (!chip_reset_n) begin
            // Emulated preset-plus-load: value undefined, left as is;
            // otherwise clearing the bit presets inverted ones
            async_val = load_emul ? q_stored : preset_inv; // R16 R17 R18
        end else if (!preset_inv && aclr) begin
            async_val = 1'b0; // R15 R20
        end else if (preset_inv && apre) begin
            async_val = 1'b1; // R15 R20
        end else if (aload) begin
            async_val = adata; // R20
        end else begin
            async_act = 1'b0;
        end
    end

    // Register output sees async controls in the same cycle
    assign q_now = async_act ? async_val : q_stored; // R20
    assign q_stored = preset_inv ? ~store : store; // R15

    // Next logical value: async, then enable, then sync path
    always_comb begin
        if (async_act) begin
            next_logic = async_val; // R20
        end else if (reg_ena) begin
            next_logic = sync_val; // R11
        end else begin
            next_logic = q_stored; // R21
        end
        next_store = preset_inv ? ~next_logic : next_logic; // R15
    end

    // Physical register bit
    // The stored bit is physical: with the wrapper on it holds the
    // inverse of the logical value, which is what makes a clear of the
    // stored bit look like a preset from outside; only the clocked
    // reset and an enabled edge ever change it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            store <= STORE_RST;
        end else if (clk_en) begin
            store <= next_store; // R11
        end
    end

    // Output selection: control bit high picks the register
    // Each output chooses on its own, so the table and the register can
    // serve unrelated functions in one cell; with both bits set the two
    // outputs carry the same registered value
    assign out0 = cell_ctrl[SEL0_BIT] ? q_now : comb_out; // R1 R2
    assign out1 = cell_ctrl[SEL1_BIT] ? q_now : comb_out; // R1 R2

    // Checks on the register, its controls and the table; all of them
    // rest while the clocked reset is held
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    logic no_async;
    assign no_async = !async_act;

    // An enabled edge with no async control pending
    sequence s_sync_edge;
        clk_en && reg_ena && no_async;
    endsequence

    // The following cycle also free of async controls, and the
    // inverter wrapper not flipped by a write at the edge between
    sequence s_quiet;
        no_async && $stable(preset_inv);
    endsequence

    a_sclr_wins: assert property ( // R14
        (s_sync_edge and sclr) ##1 s_quiet |-> q_now == 1'b0)
        else $error("sync clear did not clear register");

    a_sload_over_casc: assert property ( // R13
        (s_sync_edge and (sload && !sclr && cell_ctrl[CASC_EN_BIT]))
        ##1 s_quiet |-> q_now == $past(data_c))
        else $error("sync load lost to cascade value");

    a_hold_disabled: assert property ( // R21
        (clk_en && !reg_ena && no_async) ##1 s_quiet
        |-> q_now == $past(q_now))
        else $error("register changed while enable low");

    a_chip_reset_val: assert property ( // R17
        (!chip_reset_n && !load_emul && (aclr || apre || aload))
        |-> q_now == preset_inv)
        else $error("chip reset did not override controls");

    a_preset_now: assert property ( // R15 R20
        (chip_reset_n && preset_inv && apre) |-> q_now && async_act)
        else $error("async preset not immediate");

    a_clear_now: assert property ( // R20
        (chip_reset_n && !preset_inv && aclr && sload && data_c)
        |-> !q_now)
        else $error("async clear not ahead of sync load");

    a_arith_adder: assert property ( // R8
        (mode == MODE_ARITH && lut_mask == 16'hE896)
        |-> comb_out == (data_a ^ b_eff ^ carry_in) &&
            carry_out == ((data_a & b_eff) | (carry_in & (data_a ^ b_eff))))
        else $error("arithmetic sum or carry wrong");

    a_casc_and: assert property ( // R19
        (cell_ctrl[CASC_EN_BIT] && !cell_ctrl[CASC_OR_BIT] && !cascade_in)
        |-> !cascade_out)
        else $error("cascade AND did not gate result");

    a_out_pair: assert property ( // R2
        (clk_en && wr && addr == CELL_CTRL_ADDR &&
         wdata[SEL0_BIT] && !wdata[SEL1_BIT])
        |=> out0 == q_now && out1 == comb_out)
        else $error("output select not applied");

    a_status_read: assert property ( // R1
        (clk_en && rd && addr == CELL_STATUS_ADDR)
        |=> rdata[ST_Q_BIT] == $past(q_now) &&
            rdata[ST_COMB_BIT] == $past(comb_out))
        else $error("status read wrong");

    // Four-input AND in the full table
    a_normal_table: assert property ( // R10
        (mode == MODE_NORMAL && !cell_ctrl[CIN_LUT_BIT] &&
         !cell_ctrl[ACCUM_BIT] && lut_mask == 16'h8000)
        |-> comb_out == (data_a && data_b && data_c && data_d))
        else $error("normal table lookup wrong");

    // End cell: carry-in reaches the table in place of input d
    a_cin_table: assert property ( // R6
        (mode == MODE_NORMAL && cell_ctrl[CIN_LUT_BIT] &&
         lut_mask == 16'hFF00)
        |-> comb_out == carry_in)
        else $error("carry-in not routed into table");

    // Accumulator: the register takes the sum of a, itself and carry-in
    sequence s_accum_edge;
        s_sync_edge ##0 (mode == MODE_ARITH && cell_ctrl[ACCUM_BIT] &&
            lut_mask == 16'hE896 && !sclr && !sload &&
            !cell_ctrl[CASC_EN_BIT]);
    endsequence

    a_accum_sum: assert property ( // R7
        s_accum_edge ##1 s_quiet
        |-> q_now == ($past(data_a) ^ $past(q_now) ^ $past(carry_in)))
        else $error("accumulated sum wrong");

    // Counter with both halves all ones: data and fast carry both high
    a_counter_data: assert property ( // R12
        (mode == MODE_COUNTER && lut_mask == 16'hFFFF)
        |-> comb_out && carry_out)
        else $error("counter table halves not used");

    // Async load shows at once when no clear or preset is active
    a_aload_now: assert property ( // R20
        (chip_reset_n && aload && !(preset_inv ? apre : aclr))
        |-> q_now == adata)
        else $error("async load not immediate");

endmodule : logic_cell

/* verification/neighbour_cell.sv */
// Neighbouring cells on the carry and cascade chains
`timescale 1ns/1ps
module neighbour_cell (
    input wire logic op_a,
    input wire logic op_b,
    input wire logic op_cin,
    input wire logic casc_prev,
    input wire logic carry_up,
    output logic carry_in,
    output logic cascade_in,
    output logic routed_carry
);
    // Lower cell: adder carry goes straight into our carry input
    always_comb begin
        carry_in = (op_a & op_b) | (op_cin & (op_a | op_b));
    end
    // Lower cell: equality slice merged into its incoming cascade
    always_comb begin
        cascade_in = (op_a ~^ op_b) & casc_prev;
    end
    // Upper extra cell: puts the final carry onto routing
    always_comb begin
        routed_carry = carry_up;
    end
endmodule : neighbour_cell

/* verification/logic_cell_bench.sv */
// Self-checking bench for the programmable logic cell
`timescale 1ns/1ps
module logic_cell_bench;
    import logic_cell_pkg::*;
    logic ref_clk, rst_n, clk_en, wr, rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, v;
    logic data_a, data_b, data_c, data_d, carry_in, cascade_in;
    logic reg_ena, aclr, apre, aload, adata, sclr, sload, chip_reset_n;
    logic out0, out1, carry_out, cascade_out, routed_carry;
    logic op_a, op_b, op_cin, casc_prev;
    logic [3:0] k;
    int n_fail, n_checks;
    mode_t modes[3] = '{MODE_NORMAL, MODE_ARITH, MODE_COUNTER};

    logic_cell u_logic_cell (.ref_clk(ref_clk), .rst_n(rst_n),
        .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .data_a(data_a), .data_b(data_b), .data_c(data_c),
        .data_d(data_d), .carry_in(carry_in), .cascade_in(cascade_in),
        .reg_ena(reg_ena), .aclr(aclr), .apre(apre), .aload(aload),
        .adata(adata), .sclr(sclr), .sload(sload),
        .chip_reset_n(chip_reset_n), .out0(out0), .out1(out1),
        .carry_out(carry_out), .cascade_out(cascade_out));
    neighbour_cell u_neighbour_cell (.op_a(op_a), .op_b(op_b),
        .op_cin(op_cin), .casc_prev(casc_prev), .carry_up(carry_out),
        .carry_in(carry_in), .cascade_in(cascade_in),
        .routed_carry(routed_carry));

    // Free-running clock, 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Counts, verdict and end of run
    task automatic final_report();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // One-cycle register write
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask : reg_wr

    // One-cycle read, data sampled in the following cycle
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    // Data inputs; the lower cell is set up so carry_in equals ci
    task automatic drive(input logic [3:0] dcba, input logic ci,
                         input logic cp);
        @(posedge ref_clk);
        {data_d, data_c, data_b, data_a} <= dcba;
        op_a <= ci;
        op_b <= ci;
        casc_prev <= cp;
        #1;
    endtask : drive

    // Register controls, chip reset in the top bit
    task automatic ctl(input logic [7:0] c);
        @(posedge ref_clk);
        {chip_reset_n, reg_ena, aclr, apre, aload, adata, sclr, sload} <= c;
        #1;
    endtask : ctl

    // Clock edge, then let the updates land
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick

    // Hang guard
    initial begin
        #400000;
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        n_fail = 0;
        n_checks = 0;
        {rst_n, wr, rd, addr, wdata, op_a, op_b, op_cin, casc_prev} = '0;
        {data_a, data_b, data_c, data_d} = '0;
        {reg_ena, aclr, apre, aload, adata, sclr, sload} = '0;
        chip_reset_n = 1'b1;
        clk_en = 1'b1;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        reg_rd(CELL_CTRL_ADDR, v);
        chk(v, 32'h0);
        // Normal mode: four-input AND, carry passes through
        reg_wr(LUT_MASK_ADDR, 32'hABCD8000);
        reg_rd(LUT_MASK_ADDR, v);
        chk(v, 32'h00008000);
        reg_rd(4'hC, v);
        chk(v, 32'h0);
        for (int i = 0; i < 16; i++) begin
            k = i[3:0];
            drive(k, k[0], 1'b0);
            chk(out0, &k);
            chk(carry_out, k[0]);
        end
        // Arithmetic mode: full adder slice
        reg_wr(LUT_MASK_ADDR, 32'h0000E896);
        reg_wr(CELL_CTRL_ADDR, 32'h1);
        for (int i = 0; i < 8; i++) begin
            k = i[3:0];
            drive({2'b00, k[1:0]}, k[2], 1'b0);
            chk(out0, ^k[2:0]);
            chk(carry_out, (k[0] & k[1]) | (k[2] & (k[0] | k[1])));
            chk(routed_carry, (k[0] & k[1]) | (k[2] & (k[0] | k[1])));
        end
        // Register on out0, table on out1
        reg_wr(CELL_CTRL_ADDR, 32'h5);
        ctl(8'hC0);
        drive(4'b0001, 1'b0, 1'b0);
        drive(4'b0000, 1'b0, 1'b0);
        chk(out0, 1'b1);
        chk(out1, 1'b0);
        // Synchronous load, clear priority, enable hold
        drive(4'b0100, 1'b0, 1'b0);
        ctl(8'hC1);
        tick();
        chk(out0, 1'b1);
        ctl(8'hC3);
        tick();
        chk(out0, 1'b0);
        ctl(8'h81);
        tick();
        chk(out0, 1'b0);
        // Asynchronous controls and chip reset
        ctl(8'h8C);
        chk(out0, 1'b1);
        ctl(8'hED);
        chk(out0, 1'b0);
        ctl(8'h90);
        chk(out0, 1'b0);
        reg_wr(CELL_CTRL_ADDR, 32'h15);
        chk(out0, 1'b1);
        ctl(8'hA0);
        chk(out0, 1'b1);
        ctl(8'h00);
        chk(out0, 1'b1);
        reg_wr(CELL_CTRL_ADDR, 32'h5);
        chk(out0, 1'b0);
        ctl(8'h0C);
        chk(out0, 1'b0);
        ctl(8'h80);
        // Cascade AND and OR with table result forced
        for (int i = 0; i < 8; i++) begin
            k = i[3:0];
            reg_wr(LUT_MASK_ADDR, k[0] ? 32'hFFFF : 32'h0);
            reg_wr(CELL_CTRL_ADDR, k[1] ? 32'hC0 : 32'h40);
            drive(4'b0000, 1'b0, k[2]);
            chk(cascade_out, k[1] ? (k[0] | k[2]) : (k[0] & k[2]));
        end
        // Counter mode: sync load and clear beat the cascade value
        reg_wr(LUT_MASK_ADDR, 32'hFFFF);
        reg_wr(CELL_CTRL_ADDR, 32'h47);
        drive(4'b0100, 1'b0, 1'b0);
        ctl(8'hC1);
        tick();
        chk(out0, 1'b1);
        drive(4'b0000, 1'b0, 1'b1);
        ctl(8'hC2);
        tick();
        chk(out0, 1'b0);
        // Accumulator: b taken from the register, new sum loaded at each edge
        reg_wr(LUT_MASK_ADDR, 32'h0000E896);
        reg_wr(CELL_CTRL_ADDR, 32'h105);
        drive(4'b0001, 1'b0, 1'b0);
        ctl(8'hC0);
        chk(out0, 1'b0);
        tick();
        chk(out0, 1'b1);
        tick();
        chk(out0, 1'b0);
        // End cell: carry-in stands in for input d in the table
        reg_wr(LUT_MASK_ADDR, 32'h0000FF00);
        reg_wr(CELL_CTRL_ADDR, 32'h200);
        drive(4'b0000, 1'b1, 1'b0);
        chk(out0, 1'b1);
        drive(4'b1000, 1'b0, 1'b0);
        chk(out0, 1'b0);
        // Spare mode code behaves as normal
        reg_wr(CELL_CTRL_ADDR, 32'h2);
        reg_rd(CELL_STATUS_ADDR, v);
        chk(v[5:4], MODE_NORMAL);
        // Each mode shows in the status mode field
        foreach (modes[m]) begin
            reg_wr(CELL_CTRL_ADDR, {30'h0, modes[m]});
            reg_rd(CELL_STATUS_ADDR, v);
            chk(v[5:4], modes[m]);
        end
        // Frozen clock enable ignores a write
        @(posedge ref_clk);
        clk_en <= 1'b0;
        reg_wr(CELL_CTRL_ADDR, 32'h1);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        reg_rd(CELL_CTRL_ADDR, v);
        chk(v, {30'h0, MODE_COUNTER});
        final_report();
    end
endmodule : logic_cell_bench
